// file: verilog/smps_seq_pkg.sv
package smps_seq_pkg;

  // clock rate and timing
  localparam int unsigned CLK_MHZ            = 250;
  localparam int unsigned ZERO_CUR_TIMEOUT_US  = 50;
  localparam int unsigned ZERO_CUR_TIMEOUT_CYC = ZERO_CUR_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned VALLEY_TIMEOUT_US  = 4;
  localparam int unsigned VALLEY_TIMEOUT_CYC = VALLEY_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned PFC_FMAX_KHZ       = 250;  // frequency cap, plain default
  // least period between gate rises, rounded up
  localparam int unsigned PFC_MIN_PERIOD_CYC =
    (CLK_MHZ * 1000 + PFC_FMAX_KHZ - 1) / PFC_FMAX_KHZ;

  // register map (byte addresses)
  localparam logic [3:0]  REG_PFC_TON     = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h4;
  localparam logic [15:0] PFC_TON_RESET   = 16'h0100;

  // status field positions
  localparam int unsigned ST_STATE_LSB    = 0;
  localparam int unsigned ST_STROKE_LSB   = 2;
  localparam int unsigned ST_PROT_LATCHED = 4;
  localparam int unsigned ST_OTP_LATCHED  = 5;
  localparam int unsigned ST_LATCH_OK     = 6;
  localparam int unsigned ST_PFC_DRV      = 7;
  localparam int unsigned ST_FB_DRV       = 8;
  localparam int unsigned ST_MAINS_OK     = 9;
  localparam int unsigned ST_PFC_STARTED  = 10;
  localparam int unsigned ST_PFC_GATE     = 11;

  // comparator input indices
  localparam int unsigned IN_VCC_TRIP    = 0;
  localparam int unsigned IN_VCC_SUPPLY_LOCKOUT    = 1;
  localparam int unsigned IN_VCC_START   = 2;
  localparam int unsigned IN_HV_PRESENT  = 3;
  localparam int unsigned IN_LATCH_EN    = 4;
  localparam int unsigned IN_LATCH_PROT  = 5;
  localparam int unsigned IN_PFC_SS_DONE = 6;
  localparam int unsigned IN_FB_SS_DONE  = 7;
  localparam int unsigned IN_PFC_SS_HALF = 8;
  localparam int unsigned IN_FB_TIMEOUT  = 9;
  localparam int unsigned IN_PFC_OVP     = 10;
  localparam int unsigned IN_MAINS_STOP  = 11;
  localparam int unsigned IN_MAINS_START = 12;
  localparam int unsigned IN_MAINS_RESET = 13;
  localparam int unsigned IN_MAINS_REARM = 14;
  localparam int unsigned IN_OVERTEMP    = 15;
  localparam int unsigned IN_AUX_DEMAG   = 16;
  localparam int unsigned IN_AUX_VALLEY  = 17;
  localparam int unsigned N_IN           = 18;

  typedef enum logic [1:0] {SEQ_CHARGE, SEQ_STARTUP, SEQ_RUN, SEQ_STOP} seq_state_t;
  typedef enum logic [1:0] {STK_IDLE, STK_ON, STK_DEMAG, STK_VALLEY} stroke_t;

endpackage

// file: verilog/smps_startup_protection_sequencer.sv
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module smps_startup_protection_sequencer
  import smps_seq_pkg::*;
#(
  parameter int unsigned DEMAG_TIMEOUT_CYC  = smps_seq_pkg::ZERO_CUR_TIMEOUT_CYC,
  parameter bit          FB_TIMEOUT_LATCHED = 1'b0
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  // comparator results
  input  wire logic        i_vcc_above_trip,
  input  wire logic        i_vcc_above_lockout,
  input  wire logic        i_vcc_above_startup,
  input  wire logic        i_high_voltage_startup_in,
  input  wire logic        i_latch_above_enable,
  input  wire logic        i_latch_above_protect,
  input  wire logic        i_pfc_softstart_done,
  input  wire logic        i_flyback_softstart_done,
  input  wire logic        i_pfc_current_sense_in,
  input  wire logic        i_flyback_control_in,
  input  wire logic        i_pfc_output_sense_in,
  input  wire logic        i_mains_above_stop,
  input  wire logic        i_mains_above_start,
  input  wire logic        i_mains_above_reset,
  input  wire logic        i_mains_above_rearm,
  input  wire logic        i_overtemp,
  input  wire logic        i_pfc_aux_demag,
  input  wire logic        i_pfc_aux_valley,
  // analog controls
  output logic             o_hv_charge_en,
  output logic             o_hv_charge_high,
  output logic             o_latch_source_en,
  output logic             o_softstart_charge_en,
  output logic             o_pfc_softstart_en,
  output logic             o_pfc_softstart_full,
  output logic             o_mains_clamp_en,
  output logic             o_pfc_drv_en,
  output logic             o_fb_drv_en,
  output logic             o_pfc_gate_pulse,
  // avalon-mm slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);
  import smps_seq_pkg::*;

  localparam logic [15:0] DEMAG_TO  = 16'(DEMAG_TIMEOUT_CYC);
  localparam logic [15:0] VALLEY_TO = 16'(VALLEY_TIMEOUT_CYC);
  localparam logic [15:0] MIN_PER   = 16'(PFC_MIN_PERIOD_CYC);

  // counters are 16 bits; refuse a demag timeout or minimum period they cannot hold
  generate
    if (DEMAG_TIMEOUT_CYC < 2 || DEMAG_TIMEOUT_CYC > 65535) begin : g_bad_demag
      $error("demag timeout out of range");
    end
    if (PFC_MIN_PERIOD_CYC > 65535) begin : g_bad_period
      $error("minimum period out of range");
    end
  endgenerate

  typedef struct packed {
    logic [N_IN-1:0] sync1;
    logic [N_IN-1:0] sync2;
    seq_state_t      state;
    logic            prot_latched;
    logic            otp_latched;
    logic            mains_dropped;
    logic            latch_ok;
    logic            pfc_started;
    logic            mains_ok;
    stroke_t         stroke;
    logic            gate;
    logic [15:0]     stroke_cnt;
    logic [15:0]     period_cnt;
    logic [15:0]     ton;
    logic            ack;
    logic [31:0]     readdata;
  } seq_regs_t;

  seq_regs_t        r;
  seq_regs_t        next_r;
  logic [N_IN-1:0]  raw;
  logic [N_IN-1:0]  s;
  logic             pfc_run;
  logic             valley_now;
  logic             fault;
  logic [31:0]      status_word;

  // raw comparator vector, index order per package
  assign raw = {i_pfc_aux_valley, i_pfc_aux_demag, i_overtemp, i_mains_above_rearm,
                i_mains_above_reset, i_mains_above_start, i_mains_above_stop,
                i_pfc_output_sense_in, i_flyback_control_in, i_pfc_current_sense_in,
                i_flyback_softstart_done, i_pfc_softstart_done, i_latch_above_protect,
                i_latch_above_enable, i_high_voltage_startup_in, i_vcc_above_startup,
                i_vcc_above_lockout, i_vcc_above_trip};
  assign s = r.sync2;

  // analog controls decoded from registered state
  assign o_hv_charge_en        = (r.state == SEQ_CHARGE) && !s[IN_OVERTEMP];
  assign o_hv_charge_high      = o_hv_charge_en && s[IN_VCC_TRIP]
                                 && !s[IN_VCC_SUPPLY_LOCKOUT];
  assign o_latch_source_en     = (r.state == SEQ_STARTUP) || (r.state == SEQ_RUN);
  assign o_softstart_charge_en = o_latch_source_en;
  assign o_pfc_softstart_en    = o_latch_source_en && !r.pfc_started;
  assign o_pfc_softstart_full  = o_pfc_softstart_en && !s[IN_PFC_SS_HALF];
  assign o_mains_clamp_en      = !r.prot_latched && !r.otp_latched;
  assign o_fb_drv_en           = (r.state == SEQ_RUN);
  assign pfc_run               = o_fb_drv_en && r.pfc_started && r.mains_ok
                                 && !s[IN_PFC_OVP];
  assign o_pfc_drv_en          = pfc_run;
  assign o_pfc_gate_pulse      = r.gate;
  assign o_avs_readdata        = r.readdata;
  // one wait cycle on every access, so read data can come from a flop
  assign o_avs_waitrequest     = (i_avs_read || i_avs_write) && !r.ack;

  // status word assembly
  always_comb begin
    status_word                  = '0;
    status_word[ST_STATE_LSB+:2] = r.state;
    status_word[ST_STROKE_LSB+:2] = r.stroke;
    status_word[ST_PROT_LATCHED] = r.prot_latched;
    status_word[ST_OTP_LATCHED]  = r.otp_latched;
    status_word[ST_LATCH_OK]     = r.latch_ok;
    status_word[ST_PFC_DRV]      = pfc_run;
    status_word[ST_FB_DRV]       = o_fb_drv_en;
    status_word[ST_MAINS_OK]     = r.mains_ok;
    status_word[ST_PFC_STARTED]  = r.pfc_started;
    status_word[ST_PFC_GATE]     = r.gate;
  end

  // next-state logic for the whole block
  always_comb begin
    next_r       = r;
    valley_now   = 1'b0;
    fault        = 1'b0;
    next_r.sync1 = raw;
    next_r.sync2 = r.sync1;

    // mains brownout hysteresis for the PFC
    if (!s[IN_MAINS_STOP]) begin
      next_r.mains_ok = 1'b0;
    end else if (s[IN_MAINS_START]) begin
      next_r.mains_ok = 1'b1;
    end

    // fast latch reset: dip below reset level, then rise to rearm level
    if (r.prot_latched || r.otp_latched) begin
      if (!s[IN_MAINS_RESET]) begin
        next_r.mains_dropped = 1'b1;
      end else if (r.mains_dropped && s[IN_MAINS_REARM]) begin
        next_r.prot_latched  = 1'b0;
        next_r.otp_latched   = 1'b0;
        next_r.mains_dropped = 1'b0;
      end
    end else begin
      next_r.mains_dropped = 1'b0;
    end
    // both supplies gone clears both fault latches and the dip flag
    if (!s[IN_VCC_TRIP] && !s[IN_HV_PRESENT]) begin
      next_r.prot_latched  = 1'b0;
      next_r.otp_latched   = 1'b0;
      next_r.mains_dropped = 1'b0;
    end
    // overtemperature sets last, so a same-cycle clear never hides it
    if (s[IN_OVERTEMP]) begin
      next_r.otp_latched = 1'b1;
    end

    // start-up and protection sequencer
    case (r.state)
      SEQ_CHARGE: begin
        next_r.latch_ok    = 1'b0;
        next_r.pfc_started = 1'b0;
        if (s[IN_VCC_START]) begin
          // latched faults recharge but never restart
          if (r.prot_latched || r.otp_latched || s[IN_OVERTEMP]) begin
            next_r.state = SEQ_STOP;
          end else begin
            next_r.state = SEQ_STARTUP;
          end
        end
      end
      SEQ_STARTUP: begin
        if (s[IN_LATCH_EN]) begin
          next_r.latch_ok = 1'b1;
        end
        if (s[IN_OVERTEMP]) begin
          next_r.state = SEQ_STOP;
        end else if (!s[IN_VCC_SUPPLY_LOCKOUT]) begin
          // latch never came up: drop its source, charge again
          next_r.state = SEQ_CHARGE;
        end else if (r.latch_ok && s[IN_FB_SS_DONE]) begin
          next_r.state = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (r.latch_ok && s[IN_PFC_SS_DONE]) begin
          next_r.pfc_started = 1'b1;
        end
        if (!s[IN_LATCH_PROT]) begin
          next_r.prot_latched = 1'b1;
          fault = 1'b1;
        end
        if (s[IN_FB_TIMEOUT]) begin
          next_r.prot_latched = next_r.prot_latched | FB_TIMEOUT_LATCHED;
          fault = 1'b1;
        end
        if (s[IN_OVERTEMP] || !s[IN_VCC_SUPPLY_LOCKOUT]) begin
          fault = 1'b1;
        end
        if (fault) begin
          next_r.state       = SEQ_STOP;
          next_r.pfc_started = 1'b0;
        end
      end
      SEQ_STOP: begin
        // converters idle; wait for supply to sag to lockout
        next_r.latch_ok    = 1'b0;
        next_r.pfc_started = 1'b0;
        if (!s[IN_VCC_SUPPLY_LOCKOUT]) begin
          next_r.state = SEQ_CHARGE;
        end
      end
      default: begin
        next_r.state = SEQ_CHARGE;
      end
    endcase

    // PFC stroke engine: on-time, demag wait, valley wait
    if (r.period_cnt != 16'hFFFF) begin
      next_r.period_cnt = r.period_cnt + 16'h0001;
    end
    next_r.stroke_cnt = r.stroke_cnt + 16'h0001;
    if (!pfc_run) begin
      next_r.stroke     = STK_IDLE;
      next_r.gate       = 1'b0;
      next_r.stroke_cnt = '0;
    end else begin
      case (r.stroke)
        STK_IDLE: begin
          if (r.period_cnt >= MIN_PER) begin
            next_r.stroke     = STK_ON;
            next_r.gate       = 1'b1;
            next_r.stroke_cnt = '0;
            next_r.period_cnt = '0;
          end
        end
        STK_ON: begin
          // on-time from register, zero treated as one cycle
          if (r.stroke_cnt + 16'h0001 >= r.ton) begin
            next_r.stroke     = STK_DEMAG;
            next_r.gate       = 1'b0;
            next_r.stroke_cnt = '0;
          end
        end
        STK_DEMAG: begin
          if (s[IN_AUX_DEMAG] || (r.stroke_cnt + 16'h0001 >= DEMAG_TO)) begin
            next_r.stroke     = STK_VALLEY;
            next_r.stroke_cnt = '0;
          end
        end
        STK_VALLEY: begin
          valley_now = s[IN_AUX_VALLEY]
                       || (r.stroke_cnt + 16'h0001 >= VALLEY_TO);
          if (valley_now) begin
            next_r.stroke_cnt = '0;
            // too soon: skip this valley and wait for a later one
            if (r.period_cnt >= MIN_PER) begin
              next_r.stroke     = STK_ON;
              next_r.gate       = 1'b1;
              next_r.period_cnt = '0;
            end
          end
        end
        default: begin
          next_r.stroke = STK_IDLE;
          next_r.gate   = 1'b0;
        end
      endcase
    end

    // register bus: answer on the second cycle of each access
    next_r.ack = (i_avs_read || i_avs_write) && !r.ack;
    if (i_avs_read && !r.ack) begin
      case (i_avs_address)
        REG_PFC_TON: next_r.readdata = {16'h0000, r.ton};
        REG_STATUS:  next_r.readdata = status_word;
        default:     next_r.readdata = 32'h0000_0000;
      endcase
    end
    if (i_avs_write && r.ack && (i_avs_address == REG_PFC_TON)) begin
      if (i_avs_byteenable[0]) begin
        next_r.ton[7:0] = i_avs_writedata[7:0];
      end
      if (i_avs_byteenable[1]) begin
        next_r.ton[15:8] = i_avs_writedata[15:8];
      end
    end
  end

  // state register; reset leaves both drivers off
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r     <= '0;
      r.ton <= PFC_TON_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ---- assertions ----
  localparam int OTP_LAT = 2;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  hv_off_running_a: assert property (
    (r.state == SEQ_RUN) |-> !o_hv_charge_en)
    else $error("charge current on while running");

  charge_level_a: assert property (
    o_hv_charge_high |-> (s[IN_VCC_TRIP] && !s[IN_VCC_SUPPLY_LOCKOUT] && o_hv_charge_en))
    else $error("high charge current outside trip window");

  pfc_gate_cond_a: assert property (
    o_pfc_drv_en |-> (r.latch_ok && r.pfc_started && o_fb_drv_en))
    else $error("pfc enabled without latch and soft-start");

  latch_prot_a: assert property (
    (r.state == SEQ_RUN && !s[IN_LATCH_PROT])
    |=> (!o_fb_drv_en && !o_pfc_drv_en && r.prot_latched)[*2])
    else $error("latch input low did not latch off");

  ovp_halt_a: assert property (
    s[IN_PFC_OVP] |-> !o_pfc_drv_en ##1 !r.gate)
    else $error("pfc switched during overvoltage");

  lockout_stop_a: assert property (
    (r.state == SEQ_RUN && !s[IN_VCC_SUPPLY_LOCKOUT]) |=> (r.state == SEQ_STOP) ##1
    (r.state == SEQ_CHARGE || s[IN_VCC_SUPPLY_LOCKOUT]))
    else $error("lockout did not enter safe restart");

  latch_abort_a: assert property (
    (r.state == SEQ_STARTUP && !r.latch_ok && !s[IN_VCC_SUPPLY_LOCKOUT] && !s[IN_OVERTEMP])
    |=> (r.state == SEQ_CHARGE) && !o_latch_source_en)
    else $error("start-up not aborted at lockout");

  zero_cur_timeout_a: assert property (
    (pfc_run && r.stroke == STK_DEMAG && r.stroke_cnt == DEMAG_TO - 16'h0001)
    |=> (r.stroke != STK_DEMAG))
    else $error("internal zero current missing");

  valley_timeout_a: assert property (
    (pfc_run && r.stroke == STK_VALLEY && r.stroke_cnt == VALLEY_TO - 16'h0001
     && r.period_cnt >= MIN_PER) |=> r.gate)
    else $error("internal valley missing");

  freq_cap_a: assert property (
    $rose(r.gate) |-> ($past(r.period_cnt) >= MIN_PER))
    else $error("pfc frequency above cap");

  clamp_off_a: assert property (
    (r.prot_latched || r.otp_latched) |-> !o_mains_clamp_en)
    else $error("mains clamp on while latched");

  otp_latch_a: assert property (
    s[IN_OVERTEMP] |-> !o_hv_charge_en ##OTP_LAT r.otp_latched)
    else $error("overtemperature not handled");

endmodule // smps_startup_protection_sequencer

`default_nettype wire

// file: testbench/smps_analog_model.sv
`timescale 1ns/100ps
`default_nettype none

// comparator side: soft-start and latch caps, pfc aux winding ringing
module smps_analog_model (
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  input  wire logic i_ss_charge,
  input  wire logic i_latch_src,
  input  wire logic i_gate,
  input  wire logic i_no_demag,
  input  wire logic i_no_valley,
  output logic      o_ss_done,
  output logic      o_latch_en,
  output logic      o_demag,
  output logic      o_valley
);
  int unsigned ss_cnt;
  int unsigned lt_cnt;
  int unsigned off_cnt;

  // soft-start caps hold their charge; latch cap drains when its source is off
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ss_cnt  <= 0;
      lt_cnt  <= 0;
      off_cnt <= 0;
    end else begin
      ss_cnt  <= (i_ss_charge && ss_cnt < 20) ? ss_cnt + 1 : ss_cnt;
      lt_cnt  <= !i_latch_src ? 0 : (lt_cnt < 10) ? lt_cnt + 1 : lt_cnt;
      off_cnt <= i_gate ? 0 : (off_cnt < 4000) ? off_cnt + 1 : off_cnt;
    end
  end

  assign o_ss_done  = ss_cnt >= 20;
  assign o_latch_en = lt_cnt >= 10;
  // demag ends 20 cycles after turn-off; drain rings with a valley every 16
  assign o_demag    = !i_gate && !i_no_demag && off_cnt >= 20;
  assign o_valley   = !i_gate && !i_no_valley && off_cnt >= 30 && off_cnt % 16 < 2;
endmodule // smps_analog_model
`default_nettype wire

// file: testbench/smps_startup_protection_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none

module smps_startup_protection_sequencer_tb;
  import smps_seq_pkg::*;
  logic i_core_clk, i_rst_b, i_vcc_above_trip, i_vcc_above_lockout, i_vcc_above_startup;
  logic i_high_voltage_startup_in, i_latch_above_protect, i_pfc_current_sense_in;
  logic i_flyback_control_in, i_pfc_output_sense_in, i_mains_above_stop, i_mains_above_start;
  logic i_mains_above_reset, i_mains_above_rearm, i_overtemp, i_avs_read, i_avs_write;
  logic ss_done, i_latch_above_enable, i_pfc_aux_demag, i_pfc_aux_valley, no_demag, no_valley;
  logic o_hv_charge_en, o_hv_charge_high, o_latch_source_en, o_softstart_charge_en;
  logic o_pfc_softstart_en, o_pfc_softstart_full, o_mains_clamp_en, o_pfc_drv_en;
  logic o_fb_drv_en, o_pfc_gate_pulse, o_avs_waitrequest;
  logic [3:0]  i_avs_address, i_avs_byteenable;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  int          bad_count, check_count;

  // short demag timeout keeps the run brief; safe-restart variant
  smps_startup_protection_sequencer #(.DEMAG_TIMEOUT_CYC(50), .FB_TIMEOUT_LATCHED(1'b0))
    smps_startup_protection_sequencer_inst (.i_core_clk, .i_rst_b, .i_vcc_above_trip,
    .i_vcc_above_lockout, .i_vcc_above_startup, .i_high_voltage_startup_in,
    .i_latch_above_enable, .i_latch_above_protect, .i_pfc_softstart_done(ss_done),
    .i_flyback_softstart_done(ss_done), .i_pfc_current_sense_in, .i_flyback_control_in,
    .i_pfc_output_sense_in, .i_mains_above_stop, .i_mains_above_start, .i_mains_above_reset,
    .i_mains_above_rearm, .i_overtemp, .i_pfc_aux_demag, .i_pfc_aux_valley, .o_hv_charge_en,
    .o_hv_charge_high, .o_latch_source_en, .o_softstart_charge_en, .o_pfc_softstart_en,
    .o_pfc_softstart_full, .o_mains_clamp_en, .o_pfc_drv_en, .o_fb_drv_en, .o_pfc_gate_pulse,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest);

  smps_analog_model smps_analog_model_inst (.i_core_clk, .i_rst_b,
    .i_ss_charge(o_softstart_charge_en), .i_latch_src(o_latch_source_en),
    .i_gate(o_pfc_gate_pulse), .i_no_demag(no_demag), .i_no_valley(no_valley),
    .o_ss_done(ss_done), .o_latch_en(i_latch_above_enable), .o_demag(i_pfc_aux_demag),
    .o_valley(i_pfc_aux_valley));

  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  task automatic chk1(input logic e, input logic a);
    check_count++;
    if (a !== e) begin
      bad_count++;
      $display("[FAIL] %0t flag got %b want %b", $time, a, e);
    end
  endtask

  task automatic chk32(input logic [31:0] e, input logic [31:0] a);
    check_count++;
    if (a !== e) begin
      bad_count++;
      $display("[FAIL] %0t value got %h want %h", $time, a, e);
    end
  endtask

  // waits n edges, then lets that edge's updates settle
  task automatic wt(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic wsig(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      wt(1);
      n++;
    end
    chk1(v, s);
  endtask

  // one avalon access: held until waitrequest is seen low at an edge
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge i_core_clk);
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_write     <= wr;
    i_avs_read      <= !wr;
    // values read right after an edge are those that edge sampled
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    chk1(1'b0, o_avs_waitrequest);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
  endtask

  // on-time and off-time of the next full stroke, in cycles
  task automatic stroke(output int w, output int g);
    wsig(o_pfc_gate_pulse, 1'b1, 3000);
    w = 0;
    g = 0;
    while (o_pfc_gate_pulse === 1'b1 && w < 3000) begin
      wt(1);
      w++;
    end
    while (o_pfc_gate_pulse !== 1'b1 && g < 3000) begin
      wt(1);
      g++;
    end
  endtask

  // supply sags to lockout and is recharged; trip stays up so no power loss
  task automatic vcyc(input logic chg);
    @(posedge i_core_clk) i_vcc_above_startup <= 1'b0;
    @(posedge i_core_clk) i_vcc_above_lockout <= 1'b0;
    wt(5);
    chk1(chg, o_hv_charge_en);
    chk1(1'b0, o_fb_drv_en | o_pfc_drv_en);
    @(posedge i_core_clk) i_vcc_above_lockout <= 1'b1;
    @(posedge i_core_clk) i_vcc_above_startup <= 1'b1;
    wt(5);
  endtask

  // fast latch reset: mains dips below reset level, rises past reset, then rearm
  task automatic dip();
    @(posedge i_core_clk) {i_mains_above_stop, i_mains_above_start,
                           i_mains_above_reset, i_mains_above_rearm} <= 4'h0;
    wt(4);
    @(posedge i_core_clk) i_mains_above_reset <= 1'b1;
    wt(4);
    chk1(1'b0, o_fb_drv_en);
    @(posedge i_core_clk) {i_mains_above_stop, i_mains_above_start, i_mains_above_rearm} <= 3'h7;
    vcyc(1'b1);
    wsig(o_fb_drv_en, 1'b1, 300);
    chk1(1'b1, o_mains_clamp_en);
  endtask

  task automatic t_boot();
    chk1(1'b1, o_hv_charge_en);
    chk1(1'b0, o_hv_charge_high | o_fb_drv_en | o_pfc_drv_en);
    @(posedge i_core_clk) i_vcc_above_trip <= 1'b1;
    wt(4);
    chk1(1'b1, o_hv_charge_high);
    // start-up pulse while supply is under lockout: latch never comes up
    @(posedge i_core_clk) i_vcc_above_startup <= 1'b1;
    @(posedge i_core_clk) i_vcc_above_startup <= 1'b0;
    wsig(o_latch_source_en, 1'b1, 5);
    wsig(o_latch_source_en, 1'b0, 5);
    chk1(1'b1, o_hv_charge_en);
    @(posedge i_core_clk) i_vcc_above_lockout <= 1'b1;
    wt(4);
    chk1(1'b0, o_hv_charge_high);
    @(posedge i_core_clk) i_vcc_above_startup <= 1'b1;
    wt(4);
    chk1(1'b0, o_hv_charge_en);
    chk1(1'b1, o_latch_source_en & o_softstart_charge_en);
    chk1(1'b1, o_pfc_softstart_full);
    @(posedge i_core_clk) i_pfc_current_sense_in <= 1'b1;
    wt(4);
    chk1(1'b0, o_pfc_softstart_full);
    wsig(o_fb_drv_en, 1'b1, 100);
    wsig(o_pfc_drv_en, 1'b1, 100);
    wsig(o_pfc_softstart_en, 1'b0, 1500);
    $display("boot test done");
  endtask

  task automatic t_stroke();
    int w;
    int g;
    logic [31:0] q;
    av(1'b1, REG_PFC_TON, 32'h0000_0008, q);
    av(1'b0, REG_PFC_TON, 32'h0000_0000, q);
    chk32(32'h0000_0008, q);
    av(1'b0, 4'hC, 32'h0000_0000, q);
    chk32(32'h0000_0000, q);
    av(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk32({30'h0, SEQ_RUN}, {30'h0, q[1:0]});
    stroke(w, g);
    stroke(w, g);
    chk32(32'd8, 32'(w));
    chk1(1'b1, w + g >= PFC_MIN_PERIOD_CYC);
    @(posedge i_core_clk) no_valley <= 1'b1;
    stroke(w, g);
    chk1(1'b1, g >= VALLEY_TIMEOUT_CYC + 15 && g <= VALLEY_TIMEOUT_CYC + 40);
    @(posedge i_core_clk) no_demag <= 1'b1;
    stroke(w, g);
    chk1(1'b1, g >= VALLEY_TIMEOUT_CYC + 30 && g <= VALLEY_TIMEOUT_CYC + 70);
    @(posedge i_core_clk) {no_demag, no_valley} <= 2'b00;
    av(1'b1, REG_PFC_TON, 32'h0000_0000, q);
    stroke(w, g);
    stroke(w, g);
    chk32(32'd1, 32'(w));
    $display("stroke test done");
  endtask

  task automatic t_halt();
    @(posedge i_core_clk) i_pfc_output_sense_in <= 1'b1;
    wt(4);
    chk1(1'b0, o_pfc_drv_en);
    chk1(1'b1, o_fb_drv_en);
    @(posedge i_core_clk) i_pfc_output_sense_in <= 1'b0;
    wsig(o_pfc_drv_en, 1'b1, 20);
    @(posedge i_core_clk) {i_mains_above_stop, i_mains_above_start} <= 2'b00;
    wt(4);
    chk1(1'b0, o_pfc_drv_en);
    chk1(1'b1, o_fb_drv_en);
    @(posedge i_core_clk) i_mains_above_stop <= 1'b1;
    wt(6);
    chk1(1'b0, o_pfc_drv_en);
    @(posedge i_core_clk) i_mains_above_start <= 1'b1;
    wsig(o_pfc_drv_en, 1'b1, 20);
    $display("pfc halt test done");
  endtask

  task automatic t_fault();
    @(posedge i_core_clk) i_latch_above_protect <= 1'b0;
    wt(4);
    chk1(1'b0, o_fb_drv_en | o_pfc_drv_en);
    chk1(1'b0, o_mains_clamp_en);
    @(posedge i_core_clk) i_latch_above_protect <= 1'b1;
    vcyc(1'b1);
    wt(100);
    chk1(1'b0, o_fb_drv_en);
    // supply and high-voltage input both gone clears the latch
    @(posedge i_core_clk) {i_vcc_above_trip, i_high_voltage_startup_in} <= 2'b00;
    wt(4);
    chk1(1'b1, o_mains_clamp_en);
    @(posedge i_core_clk) {i_vcc_above_trip, i_high_voltage_startup_in} <= 2'b11;
    dip();
    vcyc(1'b1);
    wsig(o_fb_drv_en, 1'b1, 300);
    @(posedge i_core_clk) i_flyback_control_in <= 1'b1;
    wt(4);
    chk1(1'b0, o_fb_drv_en | o_pfc_drv_en);
    @(posedge i_core_clk) i_flyback_control_in <= 1'b0;
    vcyc(1'b1);
    wsig(o_fb_drv_en, 1'b1, 300);
    @(posedge i_core_clk) i_overtemp <= 1'b1;
    wt(4);
    chk1(1'b0, o_fb_drv_en | o_hv_charge_en);
    vcyc(1'b0);
    @(posedge i_core_clk) i_overtemp <= 1'b0;
    vcyc(1'b1);
    wt(100);
    chk1(1'b0, o_fb_drv_en);
    dip();
    $display("fault test done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    {i_vcc_above_trip, i_vcc_above_lockout, i_vcc_above_startup, i_pfc_current_sense_in,
     i_flyback_control_in, i_pfc_output_sense_in, i_overtemp, i_avs_read, i_avs_write,
     no_demag, no_valley, i_rst_b} = '0;
    {i_high_voltage_startup_in, i_latch_above_protect, i_mains_above_stop,
     i_mains_above_start, i_mains_above_reset, i_mains_above_rearm} = '1;
    i_avs_address = 4'h0;
    i_avs_writedata = 32'h0000_0000;
    i_avs_byteenable = 4'hF;
    bad_count = 0;
    check_count = 0;
    repeat (6) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    wt(3);
    t_boot();
    t_stroke();
    t_halt();
    t_fault();
    report_and_stop();
  end

  // tests take about 8k cycles; allow over five times that
  initial begin
    #200000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule // smps_startup_protection_sequencer_tb
`default_nettype wire
